// ==== rtl/amel_regs.svh ====
// register offsets, field positions and reset values of the alert control block
`ifndef AMEL_REGS_SVH
`define AMEL_REGS_SVH

`define AMEL_OFS_CONFIG      8'h00
`define AMEL_OFS_MASK_EN     8'h06
`define AMEL_OFS_ALERT_LIMIT 8'h07

`define AMEL_BIT_SOL  15
`define AMEL_BIT_SUL  14
`define AMEL_BIT_BOL  13
`define AMEL_BIT_BUL  12
`define AMEL_BIT_POL  11
`define AMEL_BIT_CRA  10
`define AMEL_BIT_LAF  4
`define AMEL_BIT_CRF  3
`define AMEL_BIT_OVF  2
`define AMEL_BIT_APOL 1
`define AMEL_BIT_LEN  0

`define AMEL_FUNC_TOP 15
`define AMEL_FUNC_BOT 11
`define AMEL_NUM_FUNC 5

`define AMEL_MASK_EN_RST  16'h0000
`define AMEL_LIMIT_RST    16'h0000
`define AMEL_MASK_EN_WMSK 16'hfc03

`endif

// ==== rtl/amel_pkg.sv ====
// types shared by the alert control block
package amel_pkg;

  // host register access, as handed over by the serial bus engine
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        pd_only;
  } amel_req_s;

  // one finished conversion with all its results
  typedef struct packed {
    logic        done;
    logic [15:0] sense;
    logic [15:0] bus;
    logic [15:0] power;
    logic        ovf;
  } amel_conv_s;

  // read answer towards the serial bus engine
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [15:0] data;
  } amel_rsp_s;

  typedef logic [4:0] amel_func_t;

endpackage

// ==== rtl/amel_alert.sv ====
// mask/enable register, limit compare and alert pin drive
`include "amel_regs.svh"

// Overview of operation
// R1: highest enabled limit function among 15..11 wins
// R2: sense above limit raises alert
// R3: sense below limit raises alert
// R4: bus voltage above limit raises alert
// R5: bus voltage below limit raises alert
// R6: power above limit raises alert
// R7: conversion-ready enable alerts on ready flag
// R8: limit flag marks limit-caused alert
// R9: latch mode: limit flag clears on read
// R10: transparent: flag clears after clean conversion
// R11: ready flag sets after full conversion done
// R12: config write clears ready, except power-down
// R13: mask/enable read clears ready flag
// R14: overflow flag shows arithmetic overflow
// R15: polarity bit: one high, zero low
// R16: latch bit: one latch, zero transparent
// R17: transparent alert idles once fault gone
// R18: latch alert holds until mask read
// R19: compare against separate host-written limit
// R20: alert is limit or ready, then polarity
// R21: bits nine to five read zero
module amel_alert
  import amel_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  // register access from the serial bus engine
  input  wire amel_req_s  req_i,
  output amel_rsp_s       rsp_o,
  // results of the conversion datapath
  input  wire amel_conv_s conv_i,
  // open-drain alert pin
  output logic            alert_out_o,
  output logic            alert_oe_o
);

  // stored mask/enable fields and alert limit
  logic [5:0]  en_q;
  logic [5:0]  en_d;
  logic        laf_q;
  logic        laf_d;
  logic        crf_q;
  logic        crf_d;
  logic        ovf_q;
  logic        ovf_d;
  logic        apol_q;
  logic        apol_d;
  logic        len_q;
  logic        len_d;
  logic [15:0] limit_q;
  logic [15:0] limit_d;

  // answer and pin registers
  amel_rsp_s   rsp_q;
  amel_rsp_s   rsp_d;
  logic        alert_oe_q;
  logic        alert_oe_d;
  logic        alert_out_q;
  logic        alert_out_d;

  // decode and compare terms
  logic        wr_mask;
  logic        rd_mask;
  logic        wr_limit;
  logic        rd_limit;
  logic        wr_cfg;
  logic [15:0] mask_rd_val;
  amel_func_t  func_en;
  amel_func_t  func_hit;
  logic        limit_hit;
  logic        limit_alert;
  logic        ready_alert;
  logic        alert_act;

  // one-hot pick, driven slice by slice
  wire amel_func_t func_sel;

  // reset images of the stored registers
  localparam logic [15:0] MaskEnRst = `AMEL_MASK_EN_RST;
  localparam logic [15:0] LimitRst  = `AMEL_LIMIT_RST;

  // address decoding
  always_comb begin
    wr_mask  = 1'b0;
    rd_mask  = 1'b0;
    wr_limit = 1'b0;
    rd_limit = 1'b0;
    wr_cfg   = 1'b0;
    if (req_i.addr == `AMEL_OFS_MASK_EN) begin
      wr_mask = req_i.wr;
      rd_mask = req_i.rd;
    end else if (req_i.addr == `AMEL_OFS_ALERT_LIMIT) begin
      wr_limit = req_i.wr;
      rd_limit = req_i.rd;
    end else if (req_i.addr == `AMEL_OFS_CONFIG) begin
      wr_cfg = req_i.wr;
    end
  end

  // read view of mask/enable; unused middle bits are zero
  always_comb begin
    mask_rd_val                  = 16'h0000; // [R21]
    mask_rd_val[15:10]           = en_q;
    mask_rd_val[`AMEL_BIT_LAF]   = laf_q;
    mask_rd_val[`AMEL_BIT_CRF]   = crf_q;
    mask_rd_val[`AMEL_BIT_OVF]   = ovf_q;
    mask_rd_val[`AMEL_BIT_APOL]  = apol_q;
    mask_rd_val[`AMEL_BIT_LEN]   = len_q;
  end

  // enables of the five limit functions, msb is bit 15
  assign func_en = en_q[5:1];

  // raw compare of every limit function against the limit register
  always_comb begin
    func_hit    = 5'h00;
    // sense result is two's complement, so the compare is signed
    func_hit[4] = $signed(conv_i.sense) > $signed(limit_q); // [R2] [R19]
    func_hit[3] = $signed(conv_i.sense) < $signed(limit_q); // [R3] [R19]
    func_hit[2] = conv_i.bus > limit_q;                     // [R4]
    func_hit[1] = conv_i.bus < limit_q;                     // [R5]
    func_hit[0] = conv_i.power > limit_q;                   // [R6]
  end

  // one-hot pick of the highest enabled function, one slice per bit
  for (genvar g = 0; g < `AMEL_NUM_FUNC; g++) begin : g_pick
    if (g == `AMEL_NUM_FUNC - 1) begin : g_top
      assign func_sel[g] = func_en[g]; // [R1]
    end else begin : g_low
      // any enable above this slice masks it out
      assign func_sel[g] = func_en[g] & ~(|func_en[`AMEL_NUM_FUNC - 1:g + 1]); // [R1]
    end
  end

  // lower-priority enables are ignored, not or-ed in
  assign limit_hit = |(func_sel & func_hit); // [R1]

  // configuration fields: host writes touch only the writable bits
  always_comb begin
    en_d   = en_q;
    apol_d = apol_q;
    len_d  = len_q;
    if (wr_mask) begin
      en_d   = req_i.wdata[15:10];
      apol_d = req_i.wdata[`AMEL_BIT_APOL]; // [R15]
      len_d  = req_i.wdata[`AMEL_BIT_LEN];  // [R16]
    end
  end

  // alert limit
  always_comb begin
    limit_d = limit_q;
    if (wr_limit) begin
      limit_d = req_i.wdata; // [R19]
    end
  end

  // limit flag: clear first, so that a conversion in the same cycle wins
  always_comb begin
    laf_d = laf_q;
    // transparent mode: reads never clear the flag
    if (rd_mask && len_q) begin
      laf_d = 1'b0; // [R9] [R18]
    end
    if (conv_i.done) begin
      if (limit_hit) begin
        laf_d = 1'b1; // [R8]
      end else if (!len_q) begin
        laf_d = 1'b0; // [R10] [R17]
      end
    end
  end

  // ready flag: set on done beats any clear in the same cycle
  always_comb begin
    crf_d = crf_q;
    if (rd_mask) begin
      crf_d = 1'b0; // [R13]
    end
    if (wr_cfg && !req_i.pd_only) begin
      crf_d = 1'b0; // [R12]
    end
    // done is raised only after averaging and multiplies finish
    if (conv_i.done) begin
      crf_d = 1'b1; // [R11]
    end
  end

  // overflow flag follows each conversion, reads leave it alone
  always_comb begin
    ovf_d = ovf_q;
    if (conv_i.done) begin
      ovf_d = conv_i.ovf; // [R14]
    end
  end

  // alert source and pin drive
  always_comb begin
    limit_alert = laf_d; // [R8]
    // ready alert leaves with the ready flag, so reads release it
    ready_alert = en_d[0] & crf_d; // [R7]
    alert_act   = limit_alert | ready_alert; // [R20]
    // open-drain data never rises; only the enable moves the line
    alert_out_d = 1'b0; // [R20]
    // open drain pulls low when the line is to show low
    if (apol_d) begin
      alert_oe_d = ~alert_act; // [R15] [R20]
    end else begin
      alert_oe_d = alert_act;  // [R15] [R20]
    end
  end

  // read answer, one cycle after the read strobe
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = req_i.rd;
    if (rd_mask) begin
      // value before the read side effects
      rsp_d.hit  = 1'b1;
      rsp_d.data = mask_rd_val;
    end else if (rd_limit) begin
      rsp_d.hit  = 1'b1;
      rsp_d.data = limit_q;
    end
  end

  // configuration field registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      en_q   <= MaskEnRst[15:10];
      apol_q <= MaskEnRst[`AMEL_BIT_APOL];
      len_q  <= MaskEnRst[`AMEL_BIT_LEN];
    end else begin
      en_q   <= en_d;
      apol_q <= apol_d;
      len_q  <= len_d;
    end
  end

  // alert limit register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      limit_q <= LimitRst;
    end else begin
      limit_q <= limit_d;
    end
  end

  // limit flag register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      laf_q <= MaskEnRst[`AMEL_BIT_LAF];
    end else begin
      laf_q <= laf_d;
    end
  end

  // ready flag register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      crf_q <= MaskEnRst[`AMEL_BIT_CRF];
    end else begin
      crf_q <= crf_d;
    end
  end

  // overflow flag register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ovf_q <= MaskEnRst[`AMEL_BIT_OVF];
    end else begin
      ovf_q <= ovf_d;
    end
  end

  // read answer register
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // pin registers; released during reset, so the line idles high
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      alert_oe_q  <= 1'b0;
      alert_out_q <= 1'b0;
    end else begin
      alert_oe_q  <= alert_oe_d;
      alert_out_q <= alert_out_d;
    end
  end

  assign rsp_o       = rsp_q;
  assign alert_oe_o  = alert_oe_q;
  assign alert_out_o = alert_out_q;

endmodule

// ==== testbench/amel_host.sv ====
// host model: register strobes and pulled-up alert line
module amel_host
  import amel_pkg::*;
(
  // clock and register side
  input  wire logic      clk_i,
  output amel_req_s      req_o,
  input  wire amel_rsp_s rsp_i,
  // alert line
  input  wire logic      alert_oe_i,
  output logic           alert_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // pull-up: the released line reads high
  assign alert_pin_o = alert_oe_i ? 1'b0 : 1'b1;
  initial req_o = '0;
  task automatic acc(input logic w, logic [7:0] a, logic [15:0] d, logic p,
                     output logic [15:0] q);
    @(posedge clk_i);
    #1 req_o = '{w, !w, a, d, p};
    @(posedge clk_i);
    #1 req_o = '{1'b0, 1'b0, ~a, ~d, 1'b0};
    q = rsp_i.data;
  endtask
endmodule

// ==== testbench/amel_alert_assertions.sv ====
// checker of the alert control block ports
module amel_alert_assertions
  import amel_pkg::*;
(
  // clock and inputs
  input wire logic       clk_i,
  input wire logic       resetn_i,
  input wire amel_req_s  req_i,
  input wire amel_conv_s conv_i,
  // outputs
  input wire amel_rsp_s  rsp_o,
  input wire logic       alert_out_o,
  input wire logic       alert_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire rd6 = req_i.rd && req_i.addr == 8'h06;
  wire rd7 = req_i.rd && req_i.addr == 8'h07;
  wire wr7 = req_i.wr && req_i.addr == 8'h07;
  // quiet cycle: no done, no write or mask read that could clear a flag
  sequence s_done_rd;
    conv_i.done ##1 !conv_i.done && !req_i.wr && !rd6 ##1 rd6;
  endsequence
  sequence s_wr_rd;
    wr7 ##1 !req_i.wr ##1 rd7;
  endsequence
  sequence s_rd_rd;
    rd6 && !conv_i.done ##1 !conv_i.done ##1 rd6;
  endsequence
  mask_read_a: assert property (rd6 |=> rsp_o.hit && rsp_o.data[9:5] == 5'h00)
    else $error("bad mask read");
  unmapped_read_a: assert property (req_i.rd && !rd6 && !rd7 |=> rsp_o.valid
    && !rsp_o.hit && rsp_o.data == 16'h0000)
    else $error("bad unmapped read");
  ready_set_a: assert property (s_done_rd |=> rsp_o.data[3])
    else $error("ready flag not set");
  ovf_load_a: assert property (s_done_rd |=> rsp_o.data[2] == $past(conv_i.ovf, 3))
    else $error("overflow flag wrong");
  ready_clr_a: assert property (s_rd_rd |=> !rsp_o.data[3])
    else $error("ready flag not cleared");
  limit_store_a: assert property (s_wr_rd |=> rsp_o.data == $past(req_i.wdata, 3))
    else $error("limit not stored");
  od_data_a: assert property (!alert_out_o)
    else $error("alert data not low");
  pol_idle_a: assert property (rd6 && !conv_i.done ##1 !rsp_o.data[4] |->
    alert_oe_o == rsp_o.data[1])
    else $error("idle pin level wrong");
endmodule
bind amel_alert amel_alert_assertions u_amel_alert_assertions (.clk_i, .resetn_i,
  .req_i, .conv_i, .rsp_o, .alert_out_o, .alert_oe_o);

// ==== testbench/tb.sv ====
// self-checking bench of the alert control block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import amel_pkg::*;
  localparam logic [15:0] L = 16'h0100;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  amel_req_s   req;
  amel_rsp_s   rsp;
  amel_conv_s  conv     = '0;
  logic        oe;
  logic        pin;
  logic [15:0] q;
  int          n_errors = 0;
  int          check_count = 0;
  // one hit value per limit function, others sit exactly on the limit
  logic [15:0] hs [5] = '{16'h0200, 16'hff00, L, L, L};
  logic [15:0] hb [5] = '{L, L, 16'h0200, 16'h0000, L};
  logic [15:0] hp [5] = '{L, L, L, L, 16'h0200};
  always #12.5 clk_i = ~clk_i;
  amel_alert u_amel_alert (.clk_i, .resetn_i, .req_i(req), .rsp_o(rsp), .conv_i(conv),
    .alert_out_o(), .alert_oe_o(oe));
  amel_host u_amel_host (.clk_i, .req_o(req), .rsp_i(rsp), .alert_oe_i(oe),
    .alert_pin_o(pin));
  task automatic chk(input logic [15:0] g, e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkp(input logic e);
    chk({15'h0000, pin}, {15'h0000, e});
  endtask
  task automatic wr(input logic [7:0] a, logic [15:0] d, logic p = 1'b0);
    u_amel_host.acc(1'b1, a, d, p, q);
  endtask
  task automatic rd(input logic [7:0] a, logic [15:0] e);
    u_amel_host.acc(1'b0, a, 16'h0000, 1'b0, q);
    chk(q, e);
  endtask
  task automatic cv(input logic [15:0] s, b, p, logic o = 1'b0);
    @(posedge clk_i);
    #1 conv = '{1'b1, s, b, p, o};
    @(posedge clk_i);
    #1 conv.done = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    rd(8'h06, 16'h0000);
    chkp(1'b1);
    wr(8'h07, L);
    rd(8'h07, L);
    for (int i = 0; i < 5; i++) begin
      wr(8'h06, 16'h8000 >> i);
      cv(hs[i], hb[i], hp[i]);
      chkp(1'b0);
      rd(8'h06, (16'h8000 >> i) | 16'h0018);
      cv(L, L, L);
      chkp(1'b1);
      rd(8'h06, (16'h8000 >> i) | 16'h0008);
    end
    $display("limit functions done");
    wr(8'h06, 16'hf800);
    cv(L, 16'h0200, 16'h0200);
    rd(8'h06, 16'hf808);
    wr(8'h06, 16'h8001);
    cv(16'h0200, L, L);
    cv(L, L, L);
    chkp(1'b0);
    rd(8'h06, 16'h8019);
    chkp(1'b1);
    rd(8'h06, 16'h8001);
    $display("priority and latch done");
    wr(8'h06, 16'h07fe);
    chkp(1'b0);
    cv(L, L, L, 1'b1);
    chkp(1'b1);
    wr(8'h00, 16'h0000, 1'b1);
    chkp(1'b1);
    wr(8'h00, 16'h0000);
    chkp(1'b0);
    rd(8'h06, 16'h0406);
    rd(8'h05, 16'h0000);
    $display("polarity and flags done");
    final_report();
  end
endmodule
